/* hw/twss_pkg.sv */
// shared constants and carrier types for the two-wire serial shifter
package twss_pkg;
   localparam logic [31:0] TWSS_ADDR_DATA    = 32'h00DD0058;
   localparam logic [31:0] TWSS_ADDR_CTRL    = 32'h00DD005C;
   localparam int          TWSS_BIT_DONE     = 11;
   localparam int          TWSS_BIT_INTEN    = 10;
   localparam int          TWSS_BIT_RAW_CLK  = 9;
   localparam int          TWSS_BIT_RAW_DAT  = 8;
   localparam int          TWSS_COUNT_MSB    = 7;
   localparam int          TWSS_SHIFT_BITS   = 12;
   localparam logic [3:0]  TWSS_PULSES       = 4'hB;
   localparam logic [7:0]  TWSS_COUNT_RESET  = 8'h01;
   localparam int          TWSS_UNIT_NS      = 160;
   localparam int          TWSS_CLK_NS       = 100;
   localparam logic [15:0] TWSS_HALF_UNIT_NS = 16'(TWSS_UNIT_NS / 2);
   localparam logic [15:0] TWSS_CLK_STEP_NS  = 16'(TWSS_CLK_NS);
   localparam int          TWSS_FIFO_DEPTH   = 16;

   typedef struct packed {
      logic       done;
      logic       inten;
      logic       raw_clk;
      logic       raw_dat;
      logic [7:0] count;
   } twss_ctrl_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } twss_cpu_req_t;

   typedef enum logic [2:0] {
      TWSS_IDLE,
      TWSS_SETUP,
      TWSS_LOW,
      TWSS_HIGH,
      TWSS_LAST,
      TWSS_DONE
   } twss_state_t;
endpackage

/* hw/twss_fifo.sv */
// word FIFO with valid/ready on both sides
`timescale 1ns/1ns
module twss_fifo
   import twss_pkg::*;
#(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
)(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      level;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_level;
   logic             push;
   logic             pop;

   always_comb
   begin
      in_ready    = (level != (AW+1)'(DEPTH));
      out_valid   = (level != '0);
      out_data    = mem[rd_ptr];
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_level  = level;
      if (push)
      begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop)
      begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop)
      begin
         next_level = (AW+1)'(level + 1'b1);
      end
      else if (pop && !push)
      begin
         next_level = (AW+1)'(level - 1'b1);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level  <= next_level;
      end
   end

   // storage has no reset; only the level count gates what is read
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // twss_fifo

/* hw/twss_shifter.sv */
// two-wire serial shifter: host registers, clock generator and shift engine
`timescale 1ns/1ns
module twss_shifter
   import twss_pkg::*;
#(
   parameter int FIFO_DEPTH = TWSS_FIFO_DEPTH
)(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        cpu_req,
   input  wire logic        cpu_we,
   input  wire logic [31:0] cpu_addr,
   input  wire logic [31:0] cpu_wdata,
   output logic      [31:0] cpu_rdata,
   output logic             cpu_ack,
   output logic             irq_n,
   input  wire logic        serial_clock_line_i,
   output logic             serial_clock_line_o,
   output logic             serial_clock_line_oe,
   input  wire logic        serial_data_line_i,
   output logic             serial_data_line_o,
   output logic             serial_data_line_oe
);
   twss_cpu_req_t                     cpu;
   twss_ctrl_t                        ctrl;
   twss_ctrl_t                        next_ctrl;
   twss_state_t                       state;
   twss_state_t                       next_state;
   logic [TWSS_SHIFT_BITS-1:0]        tx_shift;
   logic [TWSS_SHIFT_BITS-1:0]        next_tx_shift;
   logic [TWSS_SHIFT_BITS-1:0]        rx_word;
   logic [TWSS_SHIFT_BITS-1:0]        next_rx_word;
   logic [3:0]                        pulses_left;
   logic [3:0]                        next_pulses_left;
   logic [15:0]                       time_acc;
   logic [15:0]                       next_time_acc;
   logic                              irq_pend;
   logic                              next_irq_pend;
   logic [31:0]                       next_cpu_rdata;
   logic                              next_cpu_ack;
   logic                              clk_drive_low;
   logic                              next_clk_drive_low;
   logic                              dat_drive_low;
   logic                              next_dat_drive_low;
   logic                              scl_meta;
   logic                              scl_sense;
   logic                              sda_meta;
   logic                              sda_sense;
   logic [15:0]                       half_ns;
   logic                              half_tick;
   logic                              take;
   logic                              hit_data;
   logic                              hit_ctrl;
   logic                              ctrl_read;
   logic                              done_event;
   logic                              busy;
   logic                              fifo_in_valid;
   logic                              fifo_in_ready;
   logic                              fifo_out_valid;
   logic                              fifo_out_ready;
   logic [TWSS_SHIFT_BITS-1:0]        fifo_out_data;

   function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ref_addr);
      addr_is = (a == ref_addr);
   endfunction

   // line inputs come from outside the clock domain
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scl_meta  <= 1'b1;
         scl_sense <= 1'b1;
         sda_meta  <= 1'b1;
         sda_sense <= 1'b1;
      end
      else
      begin
         scl_meta  <= serial_clock_line_i;
         scl_sense <= scl_meta;
         sda_meta  <= serial_data_line_i;
         sda_sense <= sda_meta;
      end
   end

   assign cpu = '{req: cpu_req, we: cpu_we, addr: cpu_addr, wdata: cpu_wdata};

   // host access decode; a data write waits while the FIFO is full
   always_comb
   begin
      hit_data      = addr_is(cpu.addr, TWSS_ADDR_DATA);
      hit_ctrl      = addr_is(cpu.addr, TWSS_ADDR_CTRL);
      fifo_in_valid = cpu.req && !cpu_ack && cpu.we && hit_data;
      take          = cpu.req && !cpu_ack && (!fifo_in_valid || fifo_in_ready);
      ctrl_read     = take && !cpu.we && hit_ctrl;
   end

   twss_fifo #(
      .WIDTH (TWSS_SHIFT_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (cpu.wdata[TWSS_SHIFT_BITS-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // fractional timebase: a half period is count * 80 ns, stepped 100 ns per clock
   // count 0 is not blocked: the half period is zero and every clock ticks
   always_comb
   begin
      half_ns   = 16'(ctrl.count * TWSS_HALF_UNIT_NS);
      half_tick = (16'(time_acc + TWSS_CLK_STEP_NS) >= half_ns);
   end

   // shift engine
   always_comb
   begin
      next_state         = state;
      next_tx_shift      = tx_shift;
      next_rx_word       = rx_word;
      next_pulses_left   = pulses_left;
      next_time_acc      = 16'(time_acc + TWSS_CLK_STEP_NS);
      next_clk_drive_low = clk_drive_low;
      next_dat_drive_low = dat_drive_low;
      fifo_out_ready     = 1'b0;
      done_event         = 1'b0;
      if (half_tick)
      begin
         next_time_acc = 16'(time_acc + TWSS_CLK_STEP_NS - half_ns);
      end
      case (state)
         TWSS_IDLE:
         begin
            next_time_acc      = '0;
            // raw pulls held off once a queued word is waiting to start
            next_clk_drive_low = ctrl.raw_clk && !busy;
            next_dat_drive_low = ctrl.raw_dat && !busy;
            if (fifo_out_valid)
            begin
               fifo_out_ready     = 1'b1;
               next_tx_shift      = fifo_out_data;
               next_pulses_left   = TWSS_PULSES;
               next_clk_drive_low = 1'b0;
               next_dat_drive_low = !fifo_out_data[TWSS_SHIFT_BITS-1];
               next_state         = TWSS_SETUP;
            end
         end
         TWSS_SETUP:
         begin
            if (half_tick)
            begin
               next_clk_drive_low = 1'b1;
               next_state         = TWSS_LOW;
            end
         end
         TWSS_LOW:
         begin
            if (half_tick)
            begin
               next_clk_drive_low = 1'b0;
               next_state         = TWSS_HIGH;
            end
         end
         TWSS_HIGH:
         begin
            // a peripheral holding the clock low stretches the high phase
            // the accumulator holds, so the phase ends on the first clock the sensed line is high
            if (half_tick && !scl_sense)
            begin
               next_time_acc = time_acc;
            end
            else if (half_tick)
            begin
               next_rx_word       = {rx_word[TWSS_SHIFT_BITS-2:0], sda_sense};
               next_tx_shift      = {tx_shift[TWSS_SHIFT_BITS-2:0], 1'b0};
               next_dat_drive_low = !tx_shift[TWSS_SHIFT_BITS-2];
               next_pulses_left   = 4'(pulses_left - 1'b1);
               if (pulses_left == 4'h1)
               begin
                  next_state = TWSS_LAST;
               end
               else
               begin
                  next_clk_drive_low = 1'b1;
                  next_state         = TWSS_LOW;
               end
            end
         end
         TWSS_LAST:
         begin
            // bit zero stands after the last pulse and is sampled at its end
            if (half_tick)
            begin
               next_rx_word       = {rx_word[TWSS_SHIFT_BITS-2:0], sda_sense};
               next_dat_drive_low = 1'b0;
               next_state         = TWSS_DONE;
            end
         end
         TWSS_DONE:
         begin
            done_event = 1'b1;
            next_state = TWSS_IDLE;
         end
         default:
         begin
            next_state = TWSS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state         <= TWSS_IDLE;
         tx_shift      <= '0;
         rx_word       <= '0;
         pulses_left   <= '0;
         time_acc      <= '0;
         clk_drive_low <= 1'b0;
         dat_drive_low <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         tx_shift      <= next_tx_shift;
         rx_word       <= next_rx_word;
         pulses_left   <= next_pulses_left;
         time_acc      <= next_time_acc;
         clk_drive_low <= next_clk_drive_low;
         dat_drive_low <= next_dat_drive_low;
      end
   end

   // control register, interrupt and read data
   always_comb
   begin
      busy           = (state != TWSS_IDLE) || fifo_out_valid;
      next_ctrl      = ctrl;
      next_irq_pend  = irq_pend;
      next_cpu_ack   = take;
      next_cpu_rdata = '0;
      if (take && cpu.we && hit_ctrl)
      begin
         // done flag ignores writes; the count is kept until software rewrites it
         next_ctrl.inten   = cpu.wdata[TWSS_BIT_INTEN];
         next_ctrl.raw_clk = cpu.wdata[TWSS_BIT_RAW_CLK];
         next_ctrl.raw_dat = cpu.wdata[TWSS_BIT_RAW_DAT];
         next_ctrl.count   = cpu.wdata[TWSS_COUNT_MSB:0];
      end
      if (take && !cpu.we && hit_ctrl)
      begin
         next_cpu_rdata[TWSS_BIT_DONE]    = ctrl.done;
         next_cpu_rdata[TWSS_BIT_INTEN]   = ctrl.inten;
         next_cpu_rdata[TWSS_BIT_RAW_CLK] = scl_sense;
         next_cpu_rdata[TWSS_BIT_RAW_DAT] = sda_sense;
         next_cpu_rdata[TWSS_COUNT_MSB:0] = ctrl.count;
      end
      if (take && !cpu.we && hit_data)
      begin
         next_cpu_rdata[TWSS_SHIFT_BITS-1:0] = rx_word;
      end
      if (ctrl_read)
      begin
         next_ctrl.done = 1'b0;
         next_irq_pend  = 1'b0;
      end
      // a completion in the clearing cycle survives
      if (done_event)
      begin
         next_ctrl.done = 1'b1;
         if (ctrl.inten)
         begin
            next_irq_pend = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl      <= '{done: 1'b0, inten: 1'b0, raw_clk: 1'b0, raw_dat: 1'b0, count: TWSS_COUNT_RESET};
         irq_pend  <= 1'b0;
         cpu_ack   <= 1'b0;
         cpu_rdata <= '0;
      end
      else
      begin
         ctrl      <= next_ctrl;
         irq_pend  <= next_irq_pend;
         cpu_ack   <= next_cpu_ack;
         cpu_rdata <= next_cpu_rdata;
      end
   end

   // open-drain pins: level is always low, only the enable moves
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         irq_n                <= 1'b1;
         serial_clock_line_o  <= 1'b0;
         serial_clock_line_oe <= 1'b0;
         serial_data_line_o   <= 1'b0;
         serial_data_line_oe  <= 1'b0;
      end
      else
      begin
         irq_n                <= !next_irq_pend;
         serial_clock_line_o  <= 1'b0;
         serial_clock_line_oe <= next_clk_drive_low;
         serial_data_line_o   <= 1'b0;
         serial_data_line_oe  <= next_dat_drive_low;
      end
   end
endmodule // twss_shifter

/* sim/twss_checker.sv */
// concurrent checks on the shifter's host and line ports
`timescale 1ns/1ns
module twss_checker
   import twss_pkg::*;
#(
   parameter int FIFO_DEPTH = TWSS_FIFO_DEPTH
)(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        cpu_req,
   input wire logic        cpu_we,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   input wire logic [31:0] cpu_rdata,
   input wire logic        cpu_ack,
   input wire logic        irq_n,
   input wire logic        serial_clock_line_i,
   input wire logic        serial_clock_line_o,
   input wire logic        serial_clock_line_oe,
   input wire logic        serial_data_line_i,
   input wire logic        serial_data_line_o,
   input wire logic        serial_data_line_oe
);
   logic       rd_ctrl;
   logic       wr_ctrl;
   logic [8:0] ctl;
   logic [8:0] next_ctl;
   logic [2:0] calm;
   logic [2:0] next_calm;
   logic       clk_seen;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   assign rd_ctrl = cpu_ack && !cpu_we && cpu_addr == TWSS_ADDR_CTRL;
   assign wr_ctrl = cpu_req && !cpu_ack && cpu_we && cpu_addr == TWSS_ADDR_CTRL;
   // shadow of enable and count; calm guards the line sync delay
   always_comb
   begin
      next_ctl  = wr_ctrl ? {cpu_wdata[10], cpu_wdata[7:0]} : ctl;
      next_calm = (serial_clock_line_i != clk_seen) ? 3'h0 : ((calm == 3'h4) ? calm : calm + 3'h1);
   end
   always_ff @(posedge clk_sys or posedge sys_rst)
      if (sys_rst)
      begin
         ctl      <= {1'b0, TWSS_COUNT_RESET};
         calm     <= 3'h0;
         clk_seen <= 1'b1;
      end
      else
      begin
         ctl      <= next_ctl;
         calm     <= next_calm;
         clk_seen <= serial_clock_line_i;
      end
   sequence s_ctrl_read;
      cpu_req && !cpu_ack && !cpu_we && cpu_addr == TWSS_ADDR_CTRL;
   endsequence
   a_ack_single: assert property (cpu_ack |=> !cpu_ack)
      else $error("host ack longer than one cycle");
   a_ack_next: assert property ((cpu_req && !cpu_ack && !(cpu_we && cpu_addr == TWSS_ADDR_DATA)) |=> cpu_ack)
      else $error("host request not acked next cycle");
   a_unmapped_zero: assert property ((cpu_ack && !cpu_we && cpu_addr != TWSS_ADDR_DATA
      && cpu_addr != TWSS_ADDR_CTRL) |-> cpu_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_count_kept: assert property (rd_ctrl |-> cpu_rdata[7:0] == ctl[7:0] && cpu_rdata[10] == ctl[8])
      else $error("control count or enable lost");
   a_upper_zero: assert property ((cpu_ack && !cpu_we && cpu_addr == TWSS_ADDR_DATA) |-> cpu_rdata[31:12] == 20'h0)
      else $error("data read upper bits set");
   a_read_clears_irq: assert property (s_ctrl_read ##1 cpu_ack |-> irq_n)
      else $error("interrupt not cleared by control read");
   a_irq_holds: assert property ((!irq_n && !(cpu_req && !cpu_we && cpu_addr == TWSS_ADDR_CTRL)) |=> !irq_n)
      else $error("interrupt dropped without control read");
   a_irq_needs_en: assert property ($fell(irq_n) |-> ctl[8])
      else $error("interrupt raised while disabled");
   a_open_drain: assert property (!serial_clock_line_o && !serial_data_line_o)
      else $error("line driven high");
   a_sensed_clock: assert property ((rd_ctrl && calm == 3'h4) |-> cpu_rdata[9] == clk_seen)
      else $error("sensed clock level wrong");
endmodule // twss_checker

bind twss_shifter twss_checker #(.FIFO_DEPTH(FIFO_DEPTH)) twss_checker_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
   .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .irq_n(irq_n),
   .serial_clock_line_i(serial_clock_line_i), .serial_clock_line_o(serial_clock_line_o),
   .serial_clock_line_oe(serial_clock_line_oe), .serial_data_line_i(serial_data_line_i),
   .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe));

/* sim/twss_peer.sv */
// open-drain peripheral model: answers on the data line, may stretch the clock
`timescale 1ns/1ns
module twss_peer
   import twss_pkg::*;
(
   input  wire logic        en,
   input  wire logic        clk_line,
   input  wire logic [11:0] reply,
   input  wire logic [15:0] stretch_ns,
   output logic             clk_pull,
   output logic             dat_pull
);
   int idx;
   initial
   begin
      clk_pull = 1'b0;
      dat_pull = 1'b0;
      idx      = 0;
   end
   // change on the fall, clear of the sample at the pulse end
   always @(negedge clk_line)
      if (en && idx < TWSS_SHIFT_BITS - 1)
      begin
         dat_pull = !reply[11 - idx];
         idx      = idx + 1;
         if (stretch_ns != 16'h0)
         begin
            clk_pull = 1'b1;
            #(stretch_ns);
            clk_pull = 1'b0;
         end
      end
   // last bit has no fall of its own; released after the sample, once done is reached
   always @(posedge clk_line)
      if (en && idx == TWSS_SHIFT_BITS - 1)
      begin
         #550;
         dat_pull = !reply[0];
         #350;
         dat_pull = 1'b0;
         idx      = 0;
      end
endmodule // twss_peer

/* sim/testbench.sv */
// self-checking bench for the two-wire serial shifter
`timescale 1ns/1ns
module testbench
   import twss_pkg::*;
();
   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] msk;
   } twss_note_t;
   logic        clk_sys;
   logic        sys_rst;
   logic        cpu_req;
   logic        cpu_we;
   logic [31:0] cpu_addr;
   logic [31:0] cpu_wdata;
   logic [31:0] cpu_rdata;
   logic        cpu_ack;
   logic        irq_n;
   logic        clk_oe;
   logic        dat_oe;
   logic        clk_pull;
   logic        dat_pull;
   logic        clk_wire;
   logic        dat_wire;
   logic        peer_en;
   logic [11:0] reply;
   logic [15:0] stretch_ns;
   logic [31:0] tx;
   logic        irq_seen;
   twss_note_t  notes[$];
   twss_note_t  note;
   int          err_total = 0;
   int          tests_run = 0;
   int          cycles    = 0;
   int          pulses    = 0;
   int          wait_n;
   int          seed      = 19761;
   time         t_fall    = 0;
   time         period    = 0;
   assign clk_wire = !(clk_oe || clk_pull);
   assign dat_wire = !(dat_oe || dat_pull);
   twss_shifter #(.FIFO_DEPTH(TWSS_FIFO_DEPTH)) twss_shifter_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .irq_n(irq_n),
      .serial_clock_line_i(clk_wire), .serial_clock_line_o(), .serial_clock_line_oe(clk_oe),
      .serial_data_line_i(dat_wire), .serial_data_line_o(), .serial_data_line_oe(dat_oe));
   twss_peer twss_peer_inst (.en(peer_en), .clk_line(clk_wire), .reply(reply), .stretch_ns(stretch_ns),
      .clk_pull(clk_pull), .dat_pull(dat_pull));
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = !clk_sys;
   end
   always @(posedge clk_wire) pulses++;
   // last fall-to-fall interval of the link clock
   always @(negedge clk_wire)
   begin
      period = $time - t_fall;
      t_fall = $time;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_total++;
         final_report();
      end
   end
   // answers are checked mid-cycle, away from the launching edge
   always @(negedge clk_sys)
      if (cpu_ack === 1'b1)
      begin
         note = notes.pop_front();
         if (note.msk !== 32'h0)
            check("cpu_rdata", note.exp & note.msk, cpu_rdata & note.msk);
      end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (exp !== got)
      begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask
   task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] dat,
                      input logic [31:0] exp, input logic [31:0] msk);
      notes.push_back({exp, msk});
      cpu_req   = 1'b1;
      cpu_we    = wr;
      cpu_addr  = adr;
      cpu_wdata = dat;
      wait_n    = 0;
      do
      begin
         @(posedge clk_sys);
         wait_n++;
      end while (cpu_ack !== 1'b1 && wait_n < 5000);
      #10;
      cpu_req = 1'b0;
      idle(1);
   endtask
   task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
      bus(1'b1, adr, dat, 32'h0, 32'h0);
   endtask
   task automatic rd(input logic [31:0] adr, input logic [31:0] exp, input logic [31:0] msk);
      bus(1'b0, adr, 32'h0, exp, msk);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq_n !== 1'b0 && n < 1000)
      begin
         @(posedge clk_sys);
         n++;
      end
      idle(4);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      sys_rst    = 1'b1;
      cpu_req    = 1'b0;
      cpu_we     = 1'b0;
      cpu_addr   = 32'h0;
      cpu_wdata  = 32'h0;
      peer_en    = 1'b0;
      reply      = 12'hFFF;
      stretch_ns = 16'h0;
      irq_seen   = 1'b0;
      repeat (10) @(posedge clk_sys);
      #10;
      sys_rst = 1'b0;
      idle(1);
      rd(TWSS_ADDR_CTRL, 32'h0000_0301, '1);
      rd(TWSS_ADDR_DATA, 32'h0, 32'hFFFF_F000);
      wr(32'h00DD_0060, '1);
      rd(32'h00DD_0060, 32'h0, '1);
      wr(TWSS_ADDR_CTRL, 32'h0000_0205);
      idle(4);
      check("clock line", 32'h0, 32'(clk_wire));
      rd(TWSS_ADDR_CTRL, 32'h0000_0105, '1);
      wr(TWSS_ADDR_CTRL, 32'h0000_0105);
      idle(4);
      check("data line", 32'h0, 32'(dat_wire));
      rd(TWSS_ADDR_CTRL, 32'h0000_0205, '1);
      wr(TWSS_ADDR_CTRL, 32'h0000_0C05);
      idle(4);
      rd(TWSS_ADDR_CTRL, 32'h0000_0705, '1);
      peer_en = 1'b1;
      // last pass sends random bits into an idle peer to see the order
      for (int k = 0; k < 4; k++)
      begin
         reply = (k == 3) ? 12'hFFF : 12'($random(seed));
         tx    = $random(seed);
         if (k != 3)
            tx = tx | 32'h0000_0FFF;
         pulses = 0;
         wr(TWSS_ADDR_DATA, tx);
         wait_irq();
         check("irq_n low", 32'h0, 32'(irq_n));
         check("link pulses", 32'h0000_000B, 32'(pulses));
         check("link period", 32'h0000_0320, 32'(period));
         rd(TWSS_ADDR_CTRL, 32'h0000_0F05, '1);
         check("irq_n high", 32'h1, 32'(irq_n));
         rd(TWSS_ADDR_DATA, {20'h0, tx[11:0] & reply}, '1);
      end
      // peer holds the clock low past the host's low phase
      wr(TWSS_ADDR_CTRL, 32'h0000_0005);
      stretch_ns = 16'h028A;
      pulses     = 0;
      for (int k = 0; k < 18; k++)
      begin
         tx = $random(seed);
         wr(TWSS_ADDR_DATA, tx);
      end
      check("full refusal", 32'h1, 32'(wait_n > 10));
      while (pulses < 198 && cycles < 50000)
      begin
         @(posedge clk_sys);
         if (irq_n === 1'b0)
            irq_seen = 1'b1;
      end
      // tail of the last transfer is about two half periods
      idle(40);
      check("irq masked", 32'h0, 32'(irq_seen));
      rd(TWSS_ADDR_CTRL, 32'h0000_0B05, '1);
      rd(TWSS_ADDR_DATA, {20'h0, tx[11:0]}, '1);
      final_report();
   end
endmodule // testbench
